// >>> hdl/timer_counter.sv
// Eight-bit timer/counter with shared prescaler, AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "tmr_cfg.svh"

module timer_counter
  import tmr_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // External count pin
  input wire logic external_count_in,
  // Watchdog side
  input wire logic watchdog_tick_in,
  output logic watchdog_timeout_out,
  output logic watchdog_clear_out,
  // Interrupt request
  output logic timer_overflow_irq_out
);

  // ****************************************
  // Helpers
  // ****************************************
  // True when the low (n) bits of the prescaler are all ones
  function automatic logic low_bits_full(input logic [PRESCALE_WIDTH-1:0] cnt,
                                         input logic [3:0] n);
    logic full;
    full = 1'b1;
    for (int i = 0; i < PRESCALE_WIDTH; i++) begin
      if (i < int'(n) && !cnt[i]) begin
        full = 1'b0;
      end
    end
    return full;
  endfunction : low_bits_full

  // ****************************************
  // State
  // ****************************************
  logic bus_act_q, bus_act_d;
  logic bus_wr_q, bus_wr_d;
  logic [7:0] bus_ofs_q, bus_ofs_d;
  logic [31:0] rdata_q, rdata_d;
  option_t option_q, option_d;
  logic [7:0] timer_count_register_q, timer_count_register_d;
  logic timer_overflow_flag_q, timer_overflow_flag_d;
  logic timer_overflow_irq_enable_q, timer_overflow_irq_enable_d;
  logic sleep_q, sleep_d;
  logic [PRESCALE_WIDTH-1:0] prescaler_q, prescaler_d;
  logic [1:0] inhibit_q, inhibit_d;
  phase_t phase_q, phase_d;
  logic pin_meta_q, pin_sync_q;
  logic level_prev_q, level_prev_d;
  logic sampled_q, sampled_d;
  logic sampled_prev_q, sampled_prev_d;
  logic wd_timeout_q, wd_timeout_d;
  logic wd_clear_q, wd_clear_d;

  // ****************************************
  // Bus decode
  // ****************************************
  logic addr_take;
  logic wr_count, wr_option, wr_intctl, wr_control;
  logic [7:0] wbyte;

  assign addr_take = hsel_in && hready_in && htrans_in[1];
  assign wbyte = hwdata_in[7:0];
  assign wr_option = bus_act_q && bus_wr_q && (bus_ofs_q == `OFS_OPTION);
  assign wr_count = bus_act_q && bus_wr_q && (bus_ofs_q == `OFS_COUNT);
  assign wr_intctl = bus_act_q && bus_wr_q && (bus_ofs_q == `OFS_INTCTL);
  assign wr_control = bus_act_q && bus_wr_q && (bus_ofs_q == `OFS_CONTROL);

  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_q;

  always_comb begin
    bus_act_d = addr_take;
    bus_wr_d = hwrite_in;
    bus_ofs_d = haddr_in[7:0];
    rdata_d = 32'h0000_0000;
    if (haddr_in[31:8] != 24'h00_0000) begin
      bus_ofs_d = 8'hff;
    end
    // Read value is captured at the address phase; unmapped reads zero
    if (addr_take && !hwrite_in && haddr_in[31:8] == 24'h00_0000) begin
      case (haddr_in[7:0])
        `OFS_OPTION: rdata_d[7:0] = option_q;
        `OFS_COUNT: rdata_d[7:0] = timer_count_register_q;
        `OFS_INTCTL: begin
          rdata_d[`INTCTL_ENABLE_BIT] = timer_overflow_irq_enable_q;
          rdata_d[`INTCTL_FLAG_BIT] = timer_overflow_flag_q;
        end
        `OFS_CONTROL: rdata_d[`CONTROL_SLEEP_BIT] = sleep_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bus_act_q <= 1'b0;
      bus_wr_q <= 1'b0;
      bus_ofs_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_act_q <= bus_act_d;
      bus_wr_q <= bus_wr_d;
      bus_ofs_q <= bus_ofs_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Two stages; only the second stage feeds the counting core.
  // Adds two clocks of delay, inside the allowed increment latency.

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= external_count_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************
  // Counting core
  // ****************************************
  logic instr_tick;
  logic level, ext_edge;
  logic timer_owns;
  logic pre_event, pre_wrap;
  logic src_level;
  logic tick;
  logic [3:0] ratio_n;

  // Prescaler is a synchronous counter, not a ripple divider:
  // pin edges are therefore seen only after the synchroniser.
  // Limitation: pin rates above half the clock are lost, above a quarter when the prescaler is not in the path.

  always_comb begin
    option_d = option_q;
    timer_count_register_d = timer_count_register_q;
    timer_overflow_flag_d = timer_overflow_flag_q;
    timer_overflow_irq_enable_d = timer_overflow_irq_enable_q;
    sleep_d = sleep_q;
    prescaler_d = prescaler_q;
    inhibit_d = inhibit_q;
    phase_d = phase_q;
    wd_timeout_d = 1'b0;
    wd_clear_d = 1'b0;
    instr_tick = 1'b0;
    tick = 1'b0;

    // Four phases per instruction cycle
    case (phase_q)
      PH_ONE: phase_d = PH_TWO;
      PH_TWO: phase_d = PH_THREE;
      PH_THREE: phase_d = PH_FOUR;
      PH_FOUR: begin
        phase_d = PH_ONE;
        instr_tick = 1'b1;
      end
      default: phase_d = PH_ONE;
    endcase

    timer_owns = !option_q.prescaler_owner_select;
    level = pin_sync_q ^ option_q.count_edge_select;
    ext_edge = level && !level_prev_q;
    level_prev_d = level;
    ratio_n = {1'b0, option_q.prescale_ratio_field};

    // Prescaler input: instruction cycles, pin edges or watchdog ticks
    if (timer_owns) begin
      pre_event = option_q.count_source_select ? ext_edge : instr_tick;
      pre_wrap = low_bits_full(prescaler_q, ratio_n + 4'h1);
    end else begin
      pre_event = watchdog_tick_in;
      pre_wrap = low_bits_full(prescaler_q, ratio_n);
    end
    if (sleep_q && timer_owns) begin
      pre_event = 1'b0;
    end
    if (pre_event) begin
      prescaler_d = prescaler_q + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    end


    // Postscaled watchdog timeout
    // Timer owner: the watchdog runs unscaled, one cycle late
    wd_timeout_d = timer_owns ? watchdog_tick_in : (watchdog_tick_in && pre_wrap);

    // Phase-two and phase-four sampling of the counter source
    if (timer_owns) begin
      src_level = prescaler_q[option_q.prescale_ratio_field];
    end else begin
      src_level = level;
    end
    sampled_d = sampled_q;
    if (phase_q == PH_TWO || phase_q == PH_FOUR) begin
      sampled_d = src_level;
    end
    sampled_prev_d = sampled_q;

    if (option_q.count_source_select) begin
      tick = sampled_q && !sampled_prev_q;
    end else if (timer_owns) begin
      tick = instr_tick && pre_wrap;
    end else begin
      tick = instr_tick;
    end


    // Two-cycle hold-off after a software write to the count register
    // Counted in instruction boundaries, not in clocks
    if (instr_tick && inhibit_q != 2'h0) begin
      inhibit_d = inhibit_q - 2'h1;
    end
    if (inhibit_q != 2'h0 || sleep_q) begin
      tick = 1'b0;
    end

    if (tick) begin
      timer_count_register_d = timer_count_register_q + 8'h01;
    end
    if (wr_count) begin
      timer_count_register_d = wbyte;
      inhibit_d = `WRITE_INHIBIT_CYCLES;
    end


    // Prescaler clears: count write or watchdog clear, by owner
    // The owner not chosen never touches the shared counter
    if (wr_count && timer_owns) begin
      prescaler_d = '0;
    end
    if (wr_control && wbyte[`CONTROL_WDCLR_BIT]) begin
      wd_clear_d = 1'b1;
      if (!timer_owns) begin
        prescaler_d = '0;
      end
    end

    if (wr_option) begin
      option_d = option_t'(wbyte);
    end
    if (wr_control) begin
      sleep_d = wbyte[`CONTROL_SLEEP_BIT];
    end


    // Flag: software clear loses to a rollover in the same cycle
    // Otherwise an overflow could be lost without trace
    if (wr_intctl) begin
      timer_overflow_irq_enable_d = wbyte[`INTCTL_ENABLE_BIT];
      timer_overflow_flag_d = wbyte[`INTCTL_FLAG_BIT];
    end
    if (tick && !wr_count && timer_count_register_q == 8'hff) begin
      timer_overflow_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      option_q <= option_t'(`OPTION_RESET);
      timer_count_register_q <= `COUNT_RESET;
      timer_overflow_flag_q <= 1'b0;
      timer_overflow_irq_enable_q <= 1'b0;
      sleep_q <= 1'b0;
      prescaler_q <= '0;
      inhibit_q <= 2'h0;
      phase_q <= PH_ONE;
      // Edge history rests at the level that the reset option sees on an idle
      // low pin (falling-edge select), so no false count follows reset
      level_prev_q <= 1'b1;
      sampled_q <= 1'b1;
      sampled_prev_q <= 1'b1;
      wd_timeout_q <= 1'b0;
      wd_clear_q <= 1'b0;
    end else begin
      option_q <= option_d;
      timer_count_register_q <= timer_count_register_d;
      timer_overflow_flag_q <= timer_overflow_flag_d;
      timer_overflow_irq_enable_q <= timer_overflow_irq_enable_d;
      sleep_q <= sleep_d;
      prescaler_q <= prescaler_d;
      inhibit_q <= inhibit_d;
      phase_q <= phase_d;
      level_prev_q <= level_prev_d;
      sampled_q <= sampled_d;
      sampled_prev_q <= sampled_prev_d;
      wd_timeout_q <= wd_timeout_d;
      wd_clear_q <= wd_clear_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign watchdog_timeout_out = wd_timeout_q;
  assign watchdog_clear_out = wd_clear_q;
  // Masked request
  assign timer_overflow_irq_out = timer_overflow_flag_q && timer_overflow_irq_enable_q;

endmodule : timer_counter

// >>> hdl/tmr_cfg.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_OPTION 8'h00
`define OFS_COUNT 8'h04
`define OFS_INTCTL 8'h08
`define OFS_CONTROL 8'h0c

// ****************************************
// Field positions
// ****************************************
`define INTCTL_ENABLE_BIT 5
`define INTCTL_FLAG_BIT 2
`define CONTROL_SLEEP_BIT 0
`define CONTROL_WDCLR_BIT 1

// ****************************************
// Reset values
// ****************************************
`define OPTION_RESET 8'hff
`define COUNT_RESET 8'h00
`define INTCTL_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define WRITE_INHIBIT_CYCLES 2'h2
`define PHASES_PER_CYCLE 4

`endif

// >>> hdl/tmr_pkg.sv
// Types shared by the timer block
package tmr_pkg;

  // Configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] spare;
    logic count_source_select;
    logic count_edge_select;
    logic prescaler_owner_select;
    logic [2:0] prescale_ratio_field;
  } option_t;

  // Four oscillator phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_t;

endpackage : tmr_pkg

// >>> dv/pulse_src.sv
// Pulse source model for the external count pin
module pulse_src (
  // Clock
  input wire logic clk_in,
  // Count pin
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pin rests low between bursts
  initial pin_out = 1'b0;
  // A level of two clocks or more keeps the minimum pin widths
  task automatic burst(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (half) @(posedge clk_in);
      pin_out <= 1'b0;
    end
  endtask : burst
endmodule : pulse_src

// >>> dv/timer_counter_asserts.sv
// Concurrent checks on the timer block ports
module timer_counter_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  // Watchdog and interrupt
  input wire logic watchdog_tick_in,
  input wire logic watchdog_timeout_out,
  input wire logic watchdog_clear_out,
  input wire logic timer_overflow_irq_out
);
  logic wr;
  logic [2:0] wr_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  assign wr = hsel_in && hready_in && htrans_in[1] && hwrite_in;
  // History of write address phases
  always_ff @(posedge clk_in) begin
    if (!nrst_in)
      wr_q <= 3'h0;
    else
      wr_q <= {wr_q[1:0], wr};
  end
  sequence s_ctl_wr;
    (wr && haddr_in == 32'hc) ##1 hwdata_in[1];
  endsequence
  sequence s_far_rd;
    hsel_in && hready_in && htrans_in[1] && !hwrite_in && haddr_in[31:8] != 24'h0;
  endsequence
  property p_clr_seq;
    s_ctl_wr |-> ##[1:2] watchdog_clear_out;
  endproperty
  a_clr_seq: assert property (p_clr_seq) else $error("clear pulse missing");
  property p_clr_cause;
    $rose(watchdog_clear_out) |-> wr_q[1] || wr_q[2];
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("clear without write");
  property p_clr_once;
    watchdog_clear_out |=> !watchdog_clear_out;
  endproperty
  a_clr_once: assert property (p_clr_once) else $error("clear pulse too long");
  property p_tmo;
    watchdog_timeout_out |-> $past(watchdog_tick_in);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without tick");
  property p_tmo_once;
    watchdog_timeout_out |=> !watchdog_timeout_out;
  endproperty
  a_tmo_once: assert property (p_tmo_once) else $error("timeout pulse too long");
  property p_hi_zero;
    hrdata_out[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_far_rd;
    s_far_rd |=> hrdata_out == 32'h0;
  endproperty
  a_far_rd: assert property (p_far_rd) else $error("unmapped read not zero");
  property p_irq_hold;
    $fell(timer_overflow_irq_out) |-> wr_q[1] || wr_q[2];
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule : timer_counter_asserts

bind timer_counter timer_counter_asserts chk_i (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hready_in(hready_in),
  .hwdata_in(hwdata_in),
  .hrdata_out(hrdata_out),
  .watchdog_tick_in(watchdog_tick_in),
  .watchdog_timeout_out(watchdog_timeout_out),
  .watchdog_clear_out(watchdog_clear_out),
  .timer_overflow_irq_out(timer_overflow_irq_out)
);

// >>> dv/tb.sv
// Self-checking bench for the timer block
`include "tmr_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic tick = 1'b0;
  logic [31:0] hrdata_out, rd_q, v;
  logic rdy, resp, pin, tmo, clr, irq;
  int bad_count = 0;
  int n_compared = 0;
  int tmo_n = 0;
  int t0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) rd_q <= hrdata_out;
  always @(posedge clk_in) if (tmo === 1'b1) tmo_n <= tmo_n + 1;
  timer_counter dut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hready_in(rdy), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(rdy),
    .hresp_out(resp), .external_count_in(pin), .watchdog_tick_in(tick),
    .watchdog_timeout_out(tmo), .watchdog_clear_out(clr), .timer_overflow_irq_out(irq));
  pulse_src src (.clk_in(clk_in), .pin_out(pin));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    do @(posedge clk_in); while (rdy !== 1'b1);
  endtask : wait_rdy
  // Read data lands in v, taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy();
    #1 v = rd_q;
  endtask : bus
  // Phase alignment is unknown, so counts are checked as a window
  task automatic rate(input logic [7:0] opt, input int w, input int lo, input int hi);
    bus(1'b1, `OFS_OPTION, {24'h0, opt});
    bus(1'b1, `OFS_COUNT, 32'h0);
    repeat (w) @(posedge clk_in);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rate
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    bus(1'b0, `OFS_OPTION, 32'h0);
    chk(v, 32'hff);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, `OFS_INTCTL, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, 32'h100, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, 32'h10, 32'h0);
    chk(v, 32'h0);
    $display("reset and map test done");
    rate(8'h08, 126, 29, 31);
    rate(8'h08, 10, 0, 2);
    rate(8'h00, 126, 14, 16);
    rate(8'h01, 126, 6, 8);
    rate(8'h02, 126, 2, 4);
    $display("rate test done");
    bus(1'b1, `OFS_OPTION, 32'h08);
    bus(1'b1, `OFS_INTCTL, 32'h20);
    bus(1'b1, `OFS_COUNT, 32'hfe);
    repeat (24) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, `OFS_INTCTL, 32'h0);
    chk(v, 32'h24);
    bus(1'b1, `OFS_INTCTL, 32'h04);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, `OFS_INTCTL, 32'h0);
    chk(v, 32'h04);
    bus(1'b1, `OFS_INTCTL, 32'h0);
    $display("overflow test done");
    bus(1'b1, `OFS_CONTROL, 32'h1);
    bus(1'b1, `OFS_COUNT, 32'h40);
    repeat (40) @(posedge clk_in);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk(v, 32'h40);
    bus(1'b1, `OFS_CONTROL, 32'h0);
    $display("sleep test done");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `OFS_OPTION, (i == 0) ? 32'h28 : 32'h38);
      repeat (12) @(posedge clk_in);
      bus(1'b1, `OFS_COUNT, 32'h0);
      repeat (12) @(posedge clk_in);
      src.burst(5, 4);
      repeat (16) @(posedge clk_in);
      bus(1'b0, `OFS_COUNT, 32'h0);
      chk(v, 32'h5);
    end
    // Prescaled counter: six rising edges halve to three counts
    bus(1'b1, `OFS_OPTION, 32'h20);
    repeat (12) @(posedge clk_in);
    bus(1'b1, `OFS_COUNT, 32'h0);
    repeat (12) @(posedge clk_in);
    src.burst(6, 4);
    repeat (16) @(posedge clk_in);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk(v, 32'h3);
    $display("counter test done");
    // Hand the prescaler to the watchdog by the safe sequence
    bus(1'b1, `OFS_CONTROL, 32'h2);
    bus(1'b1, `OFS_COUNT, 32'h0);
    bus(1'b1, `OFS_OPTION, 32'h2f);
    bus(1'b1, `OFS_CONTROL, 32'h2);
    bus(1'b1, `OFS_OPTION, 32'h09);
    bus(1'b1, `OFS_CONTROL, 32'h2);
    t0 = tmo_n;
    repeat (4) begin
      @(posedge clk_in);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
    chk(tmo_n - t0, 32'h2);
    // Back to the timer: clear first, then reassign
    bus(1'b1, `OFS_CONTROL, 32'h2);
    rate(8'h00, 126, 14, 16);
    $display("watchdog test done");
    conclude();
  end
  // Whole run needs about a thousand clocks
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule : tb
